// File: shared/fbgc_consts.svh
`ifndef FBGC_CONSTS_SVH
`define FBGC_CONSTS_SVH

// clock period in ns (100 mhz)
`define FBGC_CLK_PERIOD_NS 10
// charge pump settle time after sleep, in us
`define FBGC_PUMP_READY_US 3000
// longest reset low still counted as a fault clear pulse, in ns
`define FBGC_CLEAR_PULSE_MAX_NS 3500
// dead time when the config is at its maximum, in ns
`define FBGC_DEAD_MAX_NS 6000
// bootstrap charge cycle timeout, in ns
`define FBGC_CHARGE_TIMEOUT_NS 20000
// all-ones config code selects the fixed maximum dead time
`define FBGC_DEAD_CFG_MAX 8'hff
// width of the dead-time config word
`define FBGC_DEAD_CFG_W 8
// dead-time counter width
`define FBGC_DEAD_CNT_W 10
// number of phases
`define FBGC_PHASES 2

`endif

// File: shared/fbgc_pkg.sv
package fbgc_pkg;

    // command pair of one phase
    typedef struct packed {
        logic high_cmd; // upper transistor on request
        logic low_cmd;  // lower transistor on request
    } fbgc_cmd_t;

    // gate pair of one phase
    typedef struct packed {
        logic upper_gate; // upper gate enable
        logic lower_gate; // lower gate enable
    } fbgc_gate_t;

    // per-phase drive state
    typedef enum logic [4:0] {
        FBGC_OFF    = 5'h01,
        FBGC_UPPER  = 5'h02,
        FBGC_LOWER  = 5'h04,
        FBGC_DEAD   = 5'h08,
        FBGC_CHARGE = 5'h10
    } fbgc_phase_state_t;

endpackage : fbgc_pkg

// File: src/fbgc_phase.sv
`timescale 1ns/1ps
`include "fbgc_consts.svh"

module fbgc_phase #(
    parameter int CNT_W = `FBGC_DEAD_CNT_W,
    parameter int CHARGE_CYCLES = `FBGC_CHARGE_TIMEOUT_NS / `FBGC_CLK_PERIOD_NS
) (
    input wire logic clk,                     // system clock
    input wire logic reset_n,                 // async reset, active low
    input wire logic run,                     // drive allowed (awake, pump ready)
    input wire logic force_off,               // supply fault or latched fault
    input wire fbgc_pkg::fbgc_cmd_t cmd,      // synchronised commands
    input wire logic [CNT_W-1:0] dead_cycles, // dead time in cycles, zero disables
    input wire logic boot_ok,                 // bootstrap voltage above limit
    output fbgc_pkg::fbgc_gate_t gate,        // registered gate enables
    output logic charge_timeout               // one-cycle pulse on charge timeout
);

    // wanted drive after lockout: both high resolves to lower
    wire want_lower = cmd.low_cmd;
    wire want_upper = cmd.high_cmd & ~cmd.low_cmd;

    fbgc_pkg::fbgc_phase_state_t state;
    fbgc_pkg::fbgc_phase_state_t next_state;
    logic [CNT_W-1:0] dead_cnt;       // cycles left since last turn-off
    logic [CNT_W-1:0] next_dead_cnt;
    logic [31:0] charge_cnt;          // charge cycle length so far
    logic [31:0] next_charge_cnt;
    logic last_upper;                 // side that was on before dead interval
    logic next_last_upper;

    // dead interval still open after a turn-off
    wire dead_open = (dead_cnt != '0);
    wire charge_done = (charge_cnt >= CHARGE_CYCLES - 1);

    // drive state machine
    always_comb
    begin
        next_state = state;
        next_dead_cnt = dead_open ? dead_cnt - 1'b1 : dead_cnt;
        next_charge_cnt = '0;
        next_last_upper = last_upper;
        charge_timeout = 1'b0;
        if (!run || force_off)
        begin
            next_state = fbgc_pkg::FBGC_OFF;
            next_dead_cnt = '0;
        end
        else
        begin
            case (state)
                fbgc_pkg::FBGC_OFF, fbgc_pkg::FBGC_DEAD:
                begin
                    // only the complementary turn-on waits out the interval
                    if (want_lower && !(dead_open && last_upper))
                        next_state = fbgc_pkg::FBGC_LOWER;
                    else if (want_upper && boot_ok && !(dead_open && !last_upper))
                        next_state = fbgc_pkg::FBGC_UPPER;
                    // charging turns the lower side on, so it waits out an upper turn-off
                    else if (want_upper && !boot_ok && !(dead_open && last_upper))
                        next_state = fbgc_pkg::FBGC_CHARGE;
                    else if (want_lower || want_upper)
                        next_state = fbgc_pkg::FBGC_DEAD;
                    else
                        next_state = fbgc_pkg::FBGC_OFF;
                end
                fbgc_pkg::FBGC_UPPER:
                begin
                    if (!want_upper)
                    begin
                        next_state = fbgc_pkg::FBGC_OFF;
                        next_dead_cnt = dead_cycles;
                        next_last_upper = 1'b1;
                    end
                    else if (!boot_ok)
                    begin
                        // bootstrap sagged while on: recharge via lower side
                        next_state = fbgc_pkg::FBGC_OFF;
                        next_dead_cnt = dead_cycles;
                        next_last_upper = 1'b1;
                    end
                end
                fbgc_pkg::FBGC_LOWER:
                begin
                    if (!want_lower)
                    begin
                        next_state = fbgc_pkg::FBGC_OFF;
                        next_dead_cnt = dead_cycles;
                        next_last_upper = 1'b0;
                    end
                end
                fbgc_pkg::FBGC_CHARGE:
                begin
                    // lower gate on while the bootstrap charges
                    next_charge_cnt = charge_cnt + 32'h0000_0001;
                    if (!want_upper)
                    begin
                        next_state = fbgc_pkg::FBGC_OFF;
                        next_dead_cnt = dead_cycles;
                        next_last_upper = 1'b0;
                    end
                    else if (boot_ok)
                    begin
                        next_state = fbgc_pkg::FBGC_DEAD;
                        next_dead_cnt = dead_cycles;
                        next_last_upper = 1'b0;
                    end
                    else if (charge_done)
                    begin
                        charge_timeout = 1'b1;
                        next_state = fbgc_pkg::FBGC_OFF;
                    end
                end
                default:
                    next_state = fbgc_pkg::FBGC_OFF;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= fbgc_pkg::FBGC_OFF;
            dead_cnt <= '0;
            charge_cnt <= '0;
            last_upper <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dead_cnt <= next_dead_cnt;
            charge_cnt <= next_charge_cnt;
            last_upper <= next_last_upper;
        end
    end

    // gates from flip-flops; upper and lower never together
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            gate <= '0;
        else
        begin
            gate.upper_gate <= (next_state == fbgc_pkg::FBGC_UPPER);
            gate.lower_gate <= (next_state == fbgc_pkg::FBGC_LOWER)
                            || (next_state == fbgc_pkg::FBGC_CHARGE);
        end
    end

endmodule : fbgc_phase

// File: src/fbgc_top.sv
`timescale 1ns/1ps
`include "fbgc_consts.svh"

// Notes on behaviour
// - each command drives only its own gate, except the high command's charge cycle on the lower gate
// - upper and lower never on together
// - single command turns on only its gate; high with boot low turns on lower first to charge
// - both commands high: lower wins
// - both commands low: both gates off
// - reset low holds all gates off
// - dead time before complementary turn-on
// - dead time from config, maximum fixed
// - long reset low enters sleep
// - sleep clears latched faults and flag
// - gates off until pump ready after sleep
// - short reset pulse clears bootstrap fault
// - per-phase bootstrap plus system monitors
// - single open-drain active-low fault flag
// - charge cycle before upper, timeout latches
// - supply and boot faults kill gates
// - dead time only within interval after off

module fbgc_top #(
    parameter int PUMP_READY_CYCLES = `FBGC_PUMP_READY_US * 1000 / `FBGC_CLK_PERIOD_NS,
    parameter int CHARGE_CYCLES = `FBGC_CHARGE_TIMEOUT_NS / `FBGC_CLK_PERIOD_NS,
    parameter int CNT_W = `FBGC_DEAD_CNT_W
) (
    input wire logic clk,                                  // system clock, 100 mhz
    input wire logic reset_n,                              // async reset and sleep pin, active low
    input wire logic phase_a_high_cmd,                     // phase a upper command
    input wire logic phase_a_low_cmd,                      // phase a lower command
    input wire logic phase_b_high_cmd,                     // phase b upper command
    input wire logic phase_b_low_cmd,                      // phase b lower command
    input wire logic [`FBGC_DEAD_CFG_W-1:0] dead_time_config, // dead time in cycles, ff = max
    input wire logic [`FBGC_PHASES-1:0] boot_ok,           // per-phase bootstrap above limit
    input wire logic gate_supply_ok,                       // gate supply above lockout
    input wire logic logic_supply_ok,                      // logic supply above lockout
    input wire logic over_temp,                            // overtemperature detected
    output logic phase_a_upper_gate,                       // phase a upper gate enable
    output logic phase_a_lower_gate,                       // phase a lower gate enable
    output logic phase_b_upper_gate,                       // phase b upper gate enable
    output logic phase_b_lower_gate,                       // phase b lower gate enable
    output logic fault_flag_n_o,                           // fault flag output level, always 0
    output logic fault_flag_oe,                            // fault flag pull-down enable
    output logic asleep                                    // sleep mode active
);

    localparam int CLEAR_CYCLES = `FBGC_CLEAR_PULSE_MAX_NS / `FBGC_CLK_PERIOD_NS;
    localparam int DEAD_MAX_CYCLES = `FBGC_DEAD_MAX_NS / `FBGC_CLK_PERIOD_NS;
    localparam int IN_W = 4 + `FBGC_PHASES + 3;

    // two-stage synchronisers on every asynchronous input
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic [`FBGC_DEAD_CFG_W-1:0] cfg1;
    logic [`FBGC_DEAD_CFG_W-1:0] cfg2;
    logic rst1;
    logic rst2;
    wire [IN_W-1:0] raw_in = {phase_b_low_cmd, phase_b_high_cmd, phase_a_low_cmd, phase_a_high_cmd,
                              boot_ok, gate_supply_ok, logic_supply_ok, over_temp};

    // input synchronisers; reset pin also sampled for pulse timing
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            cfg1 <= '0;
            cfg2 <= '0;
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
            cfg1 <= dead_time_config;
            cfg2 <= cfg1;
        end
    end

    // reset level sampled without reset so pulse length can be timed
    always_ff @(posedge clk)
    begin
        rst1 <= reset_n;
        rst2 <= rst1;
    end

    wire s_over_temp = sync2[0];
    wire s_vdd_ok = sync2[1];
    wire s_gate_supply_ok = sync2[2];
    wire [`FBGC_PHASES-1:0] s_boot_ok = sync2[3 +: `FBGC_PHASES];
    wire [3:0] s_cmd = sync2[IN_W-1 -: 4];

    // dead time: max code gives fixed default, else proportional
    wire dead_is_max = (cfg2 == `FBGC_DEAD_CFG_MAX);
    wire [CNT_W-1:0] dead_cycles = dead_is_max ? CNT_W'(DEAD_MAX_CYCLES)
                                               : CNT_W'(cfg2);

    // low-period counter (runs free of the async reset)
    logic [31:0] low_cnt;
    logic sleep_req;
    always_ff @(posedge clk)
    begin
        if (rst2)
        begin
            low_cnt <= '0;
            sleep_req <= 1'b0;
        end
        else
        begin
            low_cnt <= (low_cnt < CLEAR_CYCLES) ? low_cnt + 32'h0000_0001 : low_cnt;
            sleep_req <= (low_cnt >= CLEAR_CYCLES);
        end
    end

    // sleep and pump start-up
    logic [31:0] pump_cnt;
    wire pump_ready = (pump_cnt == '0);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pump_cnt <= '0;
        else if (sleep_req)
            // low long enough earlier: leave sleep with pump wait
            pump_cnt <= 32'(PUMP_READY_CYCLES);
        else if (!pump_ready)
            pump_cnt <= pump_cnt - 32'h0000_0001;
    end

    // sleep shown while pin held long or pump settling
    always_comb
    begin
        asleep = (sleep_req && !rst2) || !pump_ready;
    end

    // latched bootstrap fault, cleared by any reset (pulse or sleep)
    logic boot_fault;
    wire [`FBGC_PHASES-1:0] timeout;
    wire set_boot_fault = |timeout;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            boot_fault <= 1'b0;
        else if (!s_vdd_ok)
            boot_fault <= 1'b0; // logic undervoltage clears the latched bootstrap fault
        else if (set_boot_fault)
            boot_fault <= 1'b1;
    end

    // supply and latched faults disable; overtemp only flags
    wire force_off = !s_vdd_ok || !s_gate_supply_ok || boot_fault;
    wire run = pump_ready;
    wire any_fault = force_off || s_over_temp;

    // open-drain flag: pull low while a fault stands
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fault_flag_oe <= 1'b0;
        else
            fault_flag_oe <= any_fault;
    end
    assign fault_flag_n_o = 1'b0;

    fbgc_pkg::fbgc_gate_t gates [`FBGC_PHASES];

    // one drive unit per phase with its own bootstrap monitor
    genvar p;
    generate
        for (p = 0; p < `FBGC_PHASES; p++)
        begin : g_phase
            // high command sits above low in the pair
            wire fbgc_pkg::fbgc_cmd_t pc = {s_cmd[2*p], s_cmd[2*p+1]};
            fbgc_phase #(
                .CNT_W(CNT_W),
                .CHARGE_CYCLES(CHARGE_CYCLES)
            ) u_phase (
                .clk(clk),
                .reset_n(reset_n),
                .run(run),
                .force_off(force_off),
                .cmd(pc),
                .dead_cycles(dead_cycles),
                .boot_ok(s_boot_ok[p]),
                .gate(gates[p]),
                .charge_timeout(timeout[p])
            );
        end
    endgenerate

    // gate pins straight from phase flip-flops
    assign phase_a_upper_gate = gates[0].upper_gate;
    assign phase_a_lower_gate = gates[0].lower_gate;
    assign phase_b_upper_gate = gates[1].upper_gate;
    assign phase_b_lower_gate = gates[1].lower_gate;

endmodule : fbgc_top

// File: testbench/fbgc_monitor.sv
`timescale 1ns/1ps

module fbgc_monitor (
    input wire logic clk, // system clock
    input wire logic reset_n, // reset, active low
    input wire logic phase_a_high_cmd, // phase a upper command
    input wire logic phase_a_low_cmd, // phase a lower command
    input wire logic phase_b_high_cmd, // phase b upper command
    input wire logic phase_b_low_cmd, // phase b lower command
    input wire logic gate_supply_ok, // gate supply good
    input wire logic logic_supply_ok, // logic supply good
    input wire logic over_temp, // overtemperature
    input wire logic phase_a_upper_gate, // phase a upper gate
    input wire logic phase_a_lower_gate, // phase a lower gate
    input wire logic phase_b_upper_gate, // phase b upper gate
    input wire logic phase_b_lower_gate, // phase b lower gate
    input wire logic fault_flag_n_o, // flag level
    input wire logic fault_flag_oe, // flag pull-down enable
    input wire logic asleep // sleep active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    wire logic any_gate = phase_a_upper_gate | phase_a_lower_gate | phase_b_upper_gate | phase_b_lower_gate;

    // multi-cycle causes, long enough to pass the input synchronisers
    sequence s_a_idle;
        (!phase_a_high_cmd && !phase_a_low_cmd) [*4];
    endsequence
    sequence s_supply_bad;
        (!gate_supply_ok || !logic_supply_ok) [*4];
    endsequence
    sequence s_hot;
        over_temp [*4];
    endsequence

    property p_lock_a;
        !(phase_a_upper_gate && phase_a_lower_gate);
    endproperty
    a_lock_a: assert property (p_lock_a) else $error("phase a both gates on");
    property p_lock_b;
        !(phase_b_upper_gate && phase_b_lower_gate);
    endproperty
    a_lock_b: assert property (p_lock_b) else $error("phase b both gates on");
    // reset acts without clock, so this one is not disabled by it
    property p_reset_off;
        disable iff (1'b0) !reset_n |-> !any_gate;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("gate on in reset");
    property p_up_a;
        $rose(phase_a_upper_gate) |-> $past(phase_a_high_cmd, 3) && !$past(phase_a_low_cmd, 3);
    endproperty
    a_up_a: assert property (p_up_a) else $error("phase a upper without cause");
    property p_up_b;
        $rose(phase_b_upper_gate) |-> $past(phase_b_high_cmd, 3) && !$past(phase_b_low_cmd, 3);
    endproperty
    a_up_b: assert property (p_up_b) else $error("phase b upper without cause");
    property p_idle_a;
        s_a_idle |=> !phase_a_upper_gate && !phase_a_lower_gate;
    endproperty
    a_idle_a: assert property (p_idle_a) else $error("phase a driven while idle");
    property p_supply;
        s_supply_bad |=> !any_gate && fault_flag_oe;
    endproperty
    a_supply: assert property (p_supply) else $error("gates on in supply fault");
    property p_hot;
        s_hot |=> fault_flag_oe;
    endproperty
    a_hot: assert property (p_hot) else $error("flag missing when hot");
    property p_flag_lvl;
        fault_flag_n_o == 1'b0;
    endproperty
    a_flag_lvl: assert property (p_flag_lvl) else $error("flag level not low");
    property p_sleep;
        asleep |-> !any_gate;
    endproperty
    a_sleep: assert property (p_sleep) else $error("gate on while asleep");
endmodule : fbgc_monitor

bind fbgc_top fbgc_monitor mon (.clk(clk), .reset_n(reset_n), .phase_a_high_cmd(phase_a_high_cmd),
    .phase_a_low_cmd(phase_a_low_cmd), .phase_b_high_cmd(phase_b_high_cmd), .phase_b_low_cmd(phase_b_low_cmd),
    .gate_supply_ok(gate_supply_ok), .logic_supply_ok(logic_supply_ok), .over_temp(over_temp),
    .phase_a_upper_gate(phase_a_upper_gate), .phase_a_lower_gate(phase_a_lower_gate),
    .phase_b_upper_gate(phase_b_upper_gate), .phase_b_lower_gate(phase_b_lower_gate),
    .fault_flag_n_o(fault_flag_n_o), .fault_flag_oe(fault_flag_oe), .asleep(asleep));

// File: testbench/fbgc_host_model.sv
`timescale 1ns/1ps

// controller side: command lines move just after an edge, so the
// synchronisers always see a clean level
module fbgc_host_model (
    input wire logic clk, // system clock
    input wire fbgc_pkg::fbgc_cmd_t a_req, // wanted phase a pair
    input wire fbgc_pkg::fbgc_cmd_t b_req, // wanted phase b pair
    output logic phase_a_high_cmd, // phase a upper command
    output logic phase_a_low_cmd, // phase a lower command
    output logic phase_b_high_cmd, // phase b upper command
    output logic phase_b_low_cmd // phase b lower command
);
    // each line only follows its own request bit; straight wiring keeps
    // the request-to-pin timing fixed instead of racing the bench
    assign {phase_a_high_cmd, phase_a_low_cmd} = a_req;
    assign {phase_b_high_cmd, phase_b_low_cmd} = b_req;
endmodule : fbgc_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        fbgc_pkg::fbgc_cmd_t a; // phase a request
        fbgc_pkg::fbgc_cmd_t b; // phase b request
        logic [3:0] g; // expected gates ua la ub lb
    } fbgc_row_t;
    localparam int D = 1; // drive delay after the edge
    localparam int LIMIT = 20000; // cycle ceiling
    logic clk = 1'b0;
    logic reset_n = 1'b1; // pulled low just after time zero so async flops clear
    fbgc_pkg::fbgc_cmd_t a_req = 2'h0;
    fbgc_pkg::fbgc_cmd_t b_req = 2'h0;
    logic [7:0] dead_time_config = 8'h00;
    logic [1:0] boot_ok = 2'h3;
    logic gate_supply_ok = 1'b1;
    logic logic_supply_ok = 1'b1;
    logic over_temp = 1'b0;
    wire logic a_hi, a_lo, b_hi, b_lo, ua, la, ub, lb, flag_n, flag_oe, asleep;
    wire logic [3:0] gates = {ua, la, ub, lb};
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    // truth table rows, dead time off
    fbgc_row_t rows [5] = '{8'h99, 8'hc4, 8'h31, 8'h66, 8'h00};

    always #5 clk = ~clk;

    fbgc_host_model host (.clk(clk), .a_req(a_req), .b_req(b_req), .phase_a_high_cmd(a_hi),
        .phase_a_low_cmd(a_lo), .phase_b_high_cmd(b_hi), .phase_b_low_cmd(b_lo));
    // short pump wait and charge timeout keep the run brief
    fbgc_top #(.PUMP_READY_CYCLES(20), .CHARGE_CYCLES(10)) dut (.clk(clk), .reset_n(reset_n),
        .phase_a_high_cmd(a_hi), .phase_a_low_cmd(a_lo), .phase_b_high_cmd(b_hi), .phase_b_low_cmd(b_lo),
        .dead_time_config(dead_time_config), .boot_ok(boot_ok), .gate_supply_ok(gate_supply_ok),
        .logic_supply_ok(logic_supply_ok), .over_temp(over_temp), .phase_a_upper_gate(ua),
        .phase_a_lower_gate(la), .phase_b_upper_gate(ub), .phase_b_lower_gate(lb),
        .fault_flag_n_o(flag_n), .fault_flag_oe(flag_oe), .asleep(asleep));

    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tick(input int k);
        repeat (k)
        begin
            @(posedge clk);
            #D;
        end
    endtask : tick

    // edges until a gate shows the level, bounded
    task wait_gate(input int idx, input logic lvl, output int m);
        m = 0;
        while (gates[idx] !== lvl && m < 1000)
        begin
            tick(1);
            m++;
        end
    endtask : wait_gate

    // upper off then lower on at once: gap from upper fall to lower rise
    task measure_dead(input logic [7:0] cfg, input int exp);
        int m;
        dead_time_config = cfg;
        a_req = 2'h2;
        tick(12);
        a_req = 2'h1;
        wait_gate(3, 1'b0, m);
        wait_gate(2, 1'b1, m);
        check(m[15:0], exp[15:0]);
        a_req = 2'h0;
        // let the interval from the lower turn-off run out
        tick(exp + 8);
    endtask : measure_dead

    initial
    begin
        #D;
        reset_n = 1'b0;
        tick(2);
        a_req = 2'h2;
        tick(8);
        check(gates, 4'h0);
        a_req = 2'h0;
        reset_n = 1'b1;
        tick(40);
        foreach (rows[i])
        begin
            a_req = rows[i].a;
            b_req = rows[i].b;
            tick(8);
            check(gates, rows[i].g);
        end
        measure_dead(8'h05, 6);
        // off long before the complementary on: two sync stages plus the state edge
        a_req = 2'h2;
        tick(8);
        a_req = 2'h0;
        tick(20);
        a_req = 2'h1;
        wait_gate(2, 1'b1, n);
        check(n[15:0], 16'h0003);
        a_req = 2'h0;
        tick(8);
        measure_dead(8'hff, 601);
        // dead time off again so the charge cases run without waits
        dead_time_config = 8'h00;
        // phase a charges while phase b runs on its own monitor
        boot_ok = 2'h2;
        a_req = 2'h2;
        b_req = 2'h2;
        tick(6);
        check(gates, 4'h6);
        boot_ok = 2'h3;
        wait_gate(3, 1'b1, n);
        check(gates, 4'ha);
        a_req = 2'h0;
        tick(8);
        boot_ok = 2'h2;
        a_req = 2'h2;
        tick(30);
        boot_ok = 2'h3;
        tick(4);
        check({gates, flag_oe}, 5'h01);
        reset_n = 1'b0;
        tick(50);
        reset_n = 1'b1;
        tick(10);
        check({gates, flag_oe, asleep}, 6'h28);
        over_temp = 1'b1;
        tick(8);
        check({gates, flag_oe}, 5'h15);
        over_temp = 1'b0;
        gate_supply_ok = 1'b0;
        tick(8);
        check({gates, flag_oe}, 5'h01);
        gate_supply_ok = 1'b1;
        logic_supply_ok = 1'b0;
        tick(8);
        check({gates, flag_oe}, 5'h01);
        logic_supply_ok = 1'b1;
        tick(10);
        check({gates, flag_oe}, 5'h14);
        reset_n = 1'b0;
        tick(400);
        check({gates, asleep}, 5'h01);
        reset_n = 1'b1;
        tick(10);
        check({gates, asleep}, 5'h01);
        tick(30);
        check({gates, asleep}, 5'h14);
        finish_test();
    end
endmodule : tb_top
